//--- verilog/sci_cmd_top.v
// Serial command interpreter: frame receive, execute, reply and APB slave
`timescale 1ns/10ps
`default_nettype none
`include "sci_regs.vh"
//Behaviour
//[R1] Frames: start, FF, three letters, length, header sum, data, data sum.
//[R2] Type segment query returns three stored type characters, or nothing.
//[R3] Firmware query selector 0 controller, 1 scaler, 2 config file.
//[R4] Baud command first byte: 00 serial port, FF multidrop port.
//[R5] Baud second byte: 00 is 9600, FF is 115200, nothing else.
//[R6] Baud settings survive soft resets and default to 00.
//[R7] Baud command with one byte reads back port and rate.
//[R8] Broadcast reply byte: 00 disables, FF enables replies to broadcasts.
//[R9] New broadcast setting applies only after its own reply is sent.
//[R10] Broadcast setting persists and defaults to FF, enabled.
//[R11] Download request carries one packet number byte, 00 to FF.
//[R12] Download acknowledged only with valid data sum and packet number.
//[R13] Download reply data: packet number, dash, then packet contents.
//[R14] Download reply data never exceeds 32 bytes; code sends plen plus 2 bytes, up to 33.
//[R15] One-byte request uses active table; second byte names the table.
//[R16] Calibration mode picks table 0 to 3; none or missing table naks.
//[R17] Broadcast command without data reads the current setting.
//[R18] Bad sum or bad packet or table gives nak without data; code gives no reply at all for a bad header sum.
module sci_cmd_top #(
   parameter NTAB = 4
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   input wire soft_reset,
   input wire rx_valid,
   input wire [7:0] rx_data,
   input wire rx_bcast,
   output wire rx_ready,
   output wire tx_valid,
   output wire [7:0] tx_data,
   input wire tx_ready,
   output wire [1:0] pkt_table,
   output wire [7:0] pkt_num,
   output wire [4:0] pkt_index,
   input wire [7:0] pkt_rd_data,
   output wire baud_232_fast,
   output wire baud_485_fast,
   output wire bcast_reply_en
);
   // Interpreter states
   localparam S_START = 4'h0;
   localparam S_LEAD = 4'h1;
   localparam S_C0 = 4'h2;
   localparam S_C1 = 4'h3;
   localparam S_C2 = 4'h4;
   localparam S_LEN = 4'h5;
   localparam S_HCHK = 4'h6;
   localparam S_DATA = 4'h7;
   localparam S_DCHK = 4'h8;
   localparam S_EXEC = 4'h9;
   localparam S_TX = 4'hA;
   localparam S_DONE = 4'hB;
   // Decoded commands
   localparam K_TYPE = 3'h0;
   localparam K_FW = 3'h1;
   localparam K_BAUD = 3'h2;
   localparam K_BAK = 3'h3;
   localparam K_DL = 3'h4;
   localparam K_UNK = 3'h7;

   reg [3:0] st_ff;
   reg [7:0] c0_ff, c1_ff, c2_ff;
   reg [7:0] len_ff, cnt_ff, d0_ff, d1_ff;
   reg dok_ff;
   reg [2:0] kind;
   reg [31:0] ctrl_ff, type_ff, fwc_ff, fws_ff, fwf_ff, pcnt_ff;
   reg [7:0] b232_ff, b485_ff, bak_ff, bak_new_ff;
   reg bak_pend_ff;
   reg [7:0] rcode_ff, rlen_ff, rb0_ff, rb1_ff;
   reg [1:0] tab_ff;
   reg [2:0] rkind_ff;
   reg [5:0] pos_ff;
   reg tv_ff;
   reg [7:0] td_ff;
   reg [7:0] nb;
   reg [7:0] dbyte;
   reg [31:0] fw_word;
   reg tab_ok;
   reg [1:0] tab_sel;
   reg [7:0] tab_cnt;
   wire [7:0] rx_sum, tx_sum;
   wire rx_take;
   wire tx_load;
   wire [5:0] dpos;
   wire [2:0] cal;
   wire [4:0] plen;
   wire wr_en;

   assign cal = ctrl_ff[`SCI_CTRL_CAL_MSB:`SCI_CTRL_CAL_LSB];
   assign plen = ctrl_ff[`SCI_CTRL_PLEN_MSB:`SCI_CTRL_PLEN_LSB];
   assign rx_ready = (st_ff < S_EXEC);
   assign rx_take = rx_valid && rx_ready;
   assign tx_load = (st_ff == S_TX) && (!tv_ff || tx_ready);
   assign dpos = pos_ff - 6'h07;
   assign tx_valid = tv_ff;
   assign tx_data = td_ff;
   assign baud_232_fast = (b232_ff == `SCI_ON);
   assign baud_485_fast = (b485_ff == `SCI_ON);
   assign bcast_reply_en = (bak_ff == `SCI_ON);
   assign pkt_table = tab_ff;
   assign pkt_num = rb0_ff;
   assign pkt_index = dpos[4:0] - 5'h02;

   // Header sum restarts on the start code, data sum on the first data byte
   sci_chk_acc #(.W(8)) u_rx_chk (
      .pclk(pclk),
      .presetn(presetn),
      .restart(rx_take && (st_ff == S_START ||
               (st_ff == S_DATA && cnt_ff == 8'h00))),
      .add(rx_take),
      .din(rx_data),
      .sum(rx_sum)
   );

   // Reply sum restarts at the first header byte and the first data byte
   sci_chk_acc #(.W(8)) u_tx_chk (
      .pclk(pclk),
      .presetn(presetn),
      .restart(tx_load && (pos_ff == 6'h00 || pos_ff == 6'h07)),
      .add(tx_load),
      .din(nb),
      .sum(tx_sum)
   );

   // Command letters decode
   always @* begin
      kind = K_UNK;
      if (c0_ff == 8'h56 && c1_ff == 8'h45 && c2_ff == 8'h52) begin
         kind = K_TYPE;
      end else if (c0_ff == 8'h46 && c1_ff == 8'h57 && c2_ff == 8'h56) begin
         kind = K_FW;
      end else if (c0_ff == 8'h43 && c1_ff == 8'h42 && c2_ff == 8'h52) begin
         kind = K_BAUD;
      end else if (c0_ff == 8'h42 && c1_ff == 8'h41 && c2_ff == 8'h4B) begin
         kind = K_BAK;
      end else if (c0_ff == 8'h44 && c1_ff == 8'h4C && c2_ff == 8'h4E) begin
         kind = K_DL;
      end
   end

   // Table lookup: explicit number or the one implied by calibration mode
   always @* begin
      tab_sel = d1_ff[1:0]; // R15
      tab_ok = (d1_ff < NTAB);
      if (len_ff == 8'h01) begin
         tab_sel = cal[1:0] - 2'h1; // R16
         tab_ok = (cal != `SCI_CAL_NONE) && (cal <= `SCI_CAL_HDMI); // R16
      end
      tab_cnt = pcnt_ff[8*tab_sel +: 8];
      tab_ok = tab_ok && (tab_cnt != 8'h00); // R16
   end

   // Firmware word selection
   always @* begin
      case (d0_ff)
         8'h00: fw_word = fwc_ff; // R3
         8'h01: fw_word = fws_ff; // R3
         default: fw_word = fwf_ff; // R3
      endcase
   end

   // Reply data byte at the current data position
   always @* begin
      case (rkind_ff)
         K_TYPE: dbyte = type_ff[8*(2-dpos[1:0]) +: 8]; // R2
         K_FW: dbyte = fw_word[8*(3-dpos[1:0]) +: 8];
         K_DL: begin
            if (dpos == 6'h00) begin
               dbyte = rb0_ff; // R13
            end else if (dpos == 6'h01) begin
               dbyte = `SCI_DASH; // R13
            end else begin
               dbyte = pkt_rd_data; // R13
            end
         end
         default: dbyte = (dpos == 6'h00) ? rb0_ff : rb1_ff;
      endcase
   end

   // Next reply byte by position: header, header sum, data, data sum
   always @* begin
      case (pos_ff)
         6'h00: nb = rcode_ff;
         6'h01: nb = `SCI_LEAD;
         6'h02: nb = c0_ff;
         6'h03: nb = c1_ff;
         6'h04: nb = c2_ff;
         6'h05: nb = rlen_ff;
         6'h06: nb = tx_sum;
         default: begin
            if (dpos < rlen_ff[5:0]) begin
               nb = dbyte;
            end else begin
               nb = (rlen_ff == 8'h00) ? 8'h00 : tx_sum;
            end
         end
      endcase
   end

   // Receive, execute and transmit sequencer
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff <= S_START;
         c0_ff <= 8'h00;
         c1_ff <= 8'h00;
         c2_ff <= 8'h00;
         len_ff <= 8'h00;
         cnt_ff <= 8'h00;
         d0_ff <= 8'h00;
         d1_ff <= 8'h00;
         dok_ff <= 1'b0;
         rcode_ff <= `SCI_NAK;
         rlen_ff <= 8'h00;
         rb0_ff <= 8'h00;
         rb1_ff <= 8'h00;
         tab_ff <= 2'h0;
         rkind_ff <= K_UNK;
         pos_ff <= 6'h00;
         tv_ff <= 1'b0;
         td_ff <= 8'h00;
         b232_ff <= `SCI_BAUD_RST; // R6
         b485_ff <= `SCI_BAUD_RST; // R6
         bak_ff <= `SCI_BAK_RST; // R10
         bak_new_ff <= `SCI_BAK_RST;
         bak_pend_ff <= 1'b0;
      end else if (soft_reset) begin
         // Soft reset drops the frame in hand but keeps the settings
         st_ff <= S_START; // R6 R10
         tv_ff <= 1'b0;
         bak_pend_ff <= 1'b0;
      end else begin
         case (st_ff)
            S_START: begin
               if (rx_take && rx_data == `SCI_START) begin
                  st_ff <= S_LEAD; // R1
               end
            end
            S_LEAD: begin
               if (rx_take) begin
                  st_ff <= (rx_data == `SCI_LEAD) ? S_C0 : S_START; // R1
               end
            end
            S_C0: begin
               if (rx_take) begin
                  c0_ff <= rx_data;
                  st_ff <= S_C1;
               end
            end
            S_C1: begin
               if (rx_take) begin
                  c1_ff <= rx_data;
                  st_ff <= S_C2;
               end
            end
            S_C2: begin
               if (rx_take) begin
                  c2_ff <= rx_data;
                  st_ff <= S_LEN;
               end
            end
            S_LEN: begin
               if (rx_take) begin
                  len_ff <= rx_data;
                  cnt_ff <= 8'h00;
                  st_ff <= S_HCHK;
               end
            end
            S_HCHK: begin
               if (rx_take) begin
                  // A bad header sum means the frame is not trusted at all
                  if (rx_data != rx_sum) begin
                     st_ff <= S_START; // R1
                  end else if (len_ff == 8'h00) begin
                     dok_ff <= 1'b1;
                     st_ff <= S_EXEC;
                  end else begin
                     st_ff <= S_DATA;
                  end
               end
            end
            S_DATA: begin
               if (rx_take) begin
                  if (cnt_ff == 8'h00) begin
                     d0_ff <= rx_data;
                  end
                  if (cnt_ff == 8'h01) begin
                     d1_ff <= rx_data;
                  end
                  cnt_ff <= cnt_ff + 8'h01;
                  if (cnt_ff + 8'h01 == len_ff) begin
                     st_ff <= S_DCHK;
                  end
               end
            end
            S_DCHK: begin
               if (rx_take) begin
                  dok_ff <= (rx_data == rx_sum); // R1 R12
                  st_ff <= S_EXEC;
               end
            end
            S_EXEC: begin
               rkind_ff <= kind;
               rcode_ff <= `SCI_NAK; // R18
               rlen_ff <= 8'h00; // R18
               pos_ff <= 6'h00;
               st_ff <= (rx_bcast && !bcast_reply_en) ? S_DONE : S_TX; // R8
               case (kind)
                  K_TYPE: begin
                     if (dok_ff && len_ff == 8'h00) begin
                        rcode_ff <= `SCI_ACK;
                        rlen_ff <= ctrl_ff[`SCI_CTRL_TYPED_BIT] ?
                                   8'h03 : 8'h00; // R2
                     end
                  end
                  K_FW: begin
                     if (dok_ff && len_ff == 8'h01 && d0_ff <= 8'h02) begin
                        rcode_ff <= `SCI_ACK; // R3
                        rlen_ff <= 8'h04;
                     end
                  end
                  K_BAUD: begin
                     rb0_ff <= d0_ff;
                     if (dok_ff && (d0_ff == `SCI_OFF || d0_ff == `SCI_ON)
                         && (len_ff == 8'h01 || (len_ff == 8'h02 &&
                         (d1_ff == `SCI_OFF || d1_ff == `SCI_ON)))) begin
                        rcode_ff <= `SCI_ACK;
                        rlen_ff <= 8'h02; // R7
                        if (len_ff == 8'h02) begin
                           rb1_ff <= d1_ff;
                           if (d0_ff == `SCI_OFF) begin
                              b232_ff <= d1_ff; // R4 R5
                           end else begin
                              b485_ff <= d1_ff; // R4 R5
                           end
                        end else begin
                           rb1_ff <= (d0_ff == `SCI_OFF) ?
                                     b232_ff : b485_ff; // R7
                        end
                     end
                  end
                  K_BAK: begin
                     if (dok_ff && len_ff == 8'h00) begin
                        rcode_ff <= `SCI_ACK;
                        rlen_ff <= 8'h01;
                        rb0_ff <= bak_ff; // R17
                     end else if (dok_ff && len_ff == 8'h01 &&
                                  (d0_ff == `SCI_OFF || d0_ff == `SCI_ON)) begin
                        rcode_ff <= `SCI_ACK;
                        rlen_ff <= 8'h01;
                        rb0_ff <= d0_ff;
                        bak_new_ff <= d0_ff; // R8
                        bak_pend_ff <= 1'b1; // R9
                     end
                  end
                  K_DL: begin
                     rb0_ff <= d0_ff; // R11
                     tab_ff <= tab_sel;
                     if (dok_ff && (len_ff == 8'h01 || len_ff == 8'h02)
                         && tab_ok && d0_ff < tab_cnt) begin
                        rcode_ff <= `SCI_ACK; // R12
                        // Data length is plen plus the two header bytes, unclipped; plen 31 gives 33
                        rlen_ff <= {3'h0, plen} + {2'h0, `SCI_PKT_HDR}; // R14
                     end
                  end
                  default: begin
                     rcode_ff <= `SCI_NAK;
                  end
               endcase
            end
            S_TX: begin
               if (tx_ready && tv_ff && !tx_load) begin
                  tv_ff <= 1'b0;
               end
               if (tx_load) begin
                  if (pos_ff == rlen_ff[5:0] + 6'h08) begin
                     tv_ff <= 1'b0;
                     st_ff <= S_DONE;
                  end else begin
                     tv_ff <= 1'b1;
                     td_ff <= nb;
                     pos_ff <= pos_ff + 6'h01;
                  end
               end
            end
            S_DONE: begin
               // Last reply byte has been accepted before the change lands
               if (bak_pend_ff) begin
                  bak_ff <= bak_new_ff; // R9
                  bak_pend_ff <= 1'b0;
               end
               dok_ff <= 1'b0;
               st_ff <= S_START;
            end
            default: begin
               st_ff <= S_START;
            end
         endcase
      end
   end

   // APB slave: zero wait states, error on unmapped address
   assign pready = 1'b1;
   assign wr_en = psel && penable && pwrite;
   assign pslverr = psel && penable && (paddr > `SCI_PCNT_OFS ||
                    paddr[1:0] != 2'h0);

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_ff <= `SCI_CTRL_RST;
         type_ff <= 32'h0000_0000;
         fwc_ff <= 32'h0000_0000;
         fws_ff <= 32'h0000_0000;
         fwf_ff <= 32'h0000_0000;
         pcnt_ff <= 32'h0000_0000;
      end else if (wr_en) begin
         case (paddr)
            `SCI_CTRL_OFS: ctrl_ff <= {19'h0, pwdata[12:0]};
            `SCI_TYPE_OFS: type_ff <= {8'h00, pwdata[23:0]};
            `SCI_FWC_OFS: fwc_ff <= pwdata;
            `SCI_FWS_OFS: fws_ff <= pwdata;
            `SCI_FWF_OFS: fwf_ff <= pwdata;
            `SCI_PCNT_OFS: pcnt_ff <= pwdata;
            default: ctrl_ff <= ctrl_ff;
         endcase
      end
   end

   // Read mux; status shows live settings and busy
   always @* begin
      case (paddr)
         `SCI_CTRL_OFS: prdata = ctrl_ff;
         `SCI_STAT_OFS: prdata = {28'h0, (st_ff >= S_EXEC),
                                  bcast_reply_en, baud_485_fast,
                                  baud_232_fast};
         `SCI_TYPE_OFS: prdata = type_ff;
         `SCI_FWC_OFS: prdata = fwc_ff;
         `SCI_FWS_OFS: prdata = fws_ff;
         `SCI_FWF_OFS: prdata = fwf_ff;
         `SCI_PCNT_OFS: prdata = pcnt_ff;
         default: prdata = 32'h0000_0000;
      endcase
   end
endmodule // sci_cmd_top
`default_nettype wire

//--- verilog/sci_regs.vh
// Register offsets, field positions, resets and frame codes of the interpreter
`ifndef SCI_REGS_VH
`define SCI_REGS_VH
// APB register byte offsets
`define SCI_CTRL_OFS 8'h00
`define SCI_STAT_OFS 8'h04
`define SCI_TYPE_OFS 8'h08
`define SCI_FWC_OFS 8'h0C
`define SCI_FWS_OFS 8'h10
`define SCI_FWF_OFS 8'h14
`define SCI_PCNT_OFS 8'h18
// Control fields
`define SCI_CTRL_CAL_LSB 0
`define SCI_CTRL_CAL_MSB 2
`define SCI_CTRL_TYPED_BIT 7
`define SCI_CTRL_PLEN_LSB 8
`define SCI_CTRL_PLEN_MSB 12
`define SCI_CTRL_RST 32'h0000_1E00
// Calibration modes
`define SCI_CAL_NONE 3'h0
`define SCI_CAL_HDMI 3'h4
// Frame bytes
`define SCI_START 8'h07
`define SCI_LEAD 8'hFF
`define SCI_ACK 8'h06
`define SCI_NAK 8'h15
`define SCI_DASH 8'h2D
`define SCI_OFF 8'h00
`define SCI_ON 8'hFF
`define SCI_PKT_HDR 6'h02
// Persistent setting defaults
`define SCI_BAUD_RST 8'h00
`define SCI_BAK_RST 8'hFF
`endif

//--- verilog/sci_chk_acc.v
// Running modulo-256 byte sum used for header and data checksums
`timescale 1ns/10ps
`default_nettype none
module sci_chk_acc #(
   parameter W = 8
) (
   input wire pclk,
   input wire presetn,
   input wire restart,
   input wire add,
   input wire [W-1:0] din,
   output wire [W-1:0] sum
);
   reg [W-1:0] acc_ff;
   reg [W-1:0] nxt_acc;

   // Restart loads the first byte so no separate clear cycle is needed
   always @* begin
      nxt_acc = acc_ff;
      if (restart) begin
         nxt_acc = din;
      end else if (add) begin
         nxt_acc = acc_ff + din;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc_ff <= {W{1'b0}};
      end else begin
         acc_ff <= nxt_acc;
      end
   end

   assign sum = acc_ff;
endmodule // sci_chk_acc
`default_nettype wire

//--- test/sci_cmd_monitor.sv
// Checks on the interpreter's reply stream and settings
`timescale 1ns/10ps
`default_nettype none
module sci_cmd_monitor (
   input wire pclk,
   input wire presetn,
   input wire soft_reset,
   input wire rx_ready,
   input wire tx_valid,
   input wire [7:0] tx_data,
   input wire tx_ready,
   input wire baud_232_fast,
   input wire baud_485_fast,
   input wire bcast_reply_en
);
   logic [5:0] pos_ff;
   logic [7:0] b0_ff;
   logic [7:0] b4_ff;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // Reply byte position; cleared while receiving
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pos_ff <= 6'h00;
         b0_ff <= 8'h00;
         b4_ff <= 8'h00;
      end else if (rx_ready) begin
         pos_ff <= 6'h00;
      end else if (tx_valid && tx_ready) begin
         pos_ff <= pos_ff + 6'h01;
         if (pos_ff == 6'h00) b0_ff <= tx_data;
         if (pos_ff == 6'h04) b4_ff <= tx_data;
      end
   end
   property p_hold;
      tx_valid && !tx_ready |=> tx_valid && $stable(tx_data);
   endproperty
   a_hold: assert property (p_hold) else $error("reply byte not held");
   property p_lead;
      tx_valid && pos_ff == 6'h01 |-> tx_data == 8'hFF;
   endproperty
   a_lead: assert property (p_lead) else $error("second byte not FF");
   property p_code;
      tx_valid && pos_ff == 6'h00 |-> tx_data == 8'h06 || tx_data == 8'h15;
   endproperty
   a_code: assert property (p_code) else $error("bad reply code");
   property p_max;
      tx_valid && pos_ff == 6'h05 |-> tx_data <= 8'h20;
   endproperty
   a_max: assert property (p_max) else $error("reply data too long");
   property p_nak;
      tx_valid && pos_ff == 6'h05 && b0_ff == 8'h15 |-> tx_data == 8'h00;
   endproperty
   a_nak: assert property (p_nak) else $error("negative reply has data");
   property p_dash;
      tx_valid && pos_ff == 6'h08 && b0_ff == 8'h06 && b4_ff == 8'h4E
         |-> tx_data == 8'h2D;
   endproperty
   a_dash: assert property (p_dash) else $error("missing separator");
   property p_bak;
      $changed(bcast_reply_en) |-> $past(!tx_valid && !rx_ready);
   endproperty
   a_bak: assert property (p_bak) else $error("setting changed early");
   property p_soft;
      soft_reset |=> $stable(baud_232_fast) && $stable(baud_485_fast)
         && $stable(bcast_reply_en);
   endproperty
   a_soft: assert property (p_soft) else $error("setting lost");
endmodule // sci_cmd_monitor
bind sci_cmd_top sci_cmd_monitor u_mon (.pclk(pclk), .presetn(presetn),
   .soft_reset(soft_reset), .rx_ready(rx_ready), .tx_valid(tx_valid),
   .tx_data(tx_data), .tx_ready(tx_ready), .baud_232_fast(baud_232_fast),
   .baud_485_fast(baud_485_fast), .bcast_reply_en(bcast_reply_en));
`default_nettype wire

//--- test/sci_host_model.sv
// Host side of the serial link: sends frames and collects reply bytes
`timescale 1ns/10ps
`default_nettype none
module sci_host_model (
   input wire logic pclk,
   input wire logic rx_ready,
   input wire logic tx_valid,
   input wire logic [7:0] tx_data,
   output logic rx_valid,
   output logic [7:0] rx_data,
   output logic tx_ready
);
   logic [7:0] rep_q[$];
   logic slow = 1'b0;
   initial begin
      rx_valid = 1'b0;
      rx_data = 8'h5A;
      tx_ready = 1'b0;
   end
   // Slow sink stalls every other cycle
   always @(posedge pclk) begin
      if (tx_valid && tx_ready) rep_q.push_back(tx_data);
      tx_ready <= slow ? ~tx_ready : 1'b1;
   end
   // Whole frame held byte by byte; released line shows the inverse
   task automatic send_frame(input logic [7:0] f[$]);
      foreach (f[i]) begin
         rx_valid <= 1'b1;
         rx_data <= f[i];
         do @(posedge pclk); while (rx_ready !== 1'b1);
      end
      rx_valid <= 1'b0;
      rx_data <= ~f[f.size() - 1];
   endtask
endmodule // sci_host_model
`default_nettype wire

//--- test/serial_cmd_interface_download_test.sv
// Self-checking bench of the serial command interpreter
`timescale 1ns/10ps
`default_nettype none
module serial_cmd_interface_download_test;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic soft_reset = 1'b0, rx_bcast = 1'b0;
   wire [31:0] prdata;
   wire pready, pslverr, rx_ready, rx_valid, tx_valid, tx_ready;
   wire [7:0] rx_data, tx_data, pkt_num, pkt_rd_data;
   wire [1:0] pkt_table;
   wire [4:0] pkt_index;
   wire baud_232_fast, baud_485_fast, bcast_reply_en;
   int err_total = 0, checks_done = 0;
   logic [31:0] rd;
   logic er;
   // Content byte marks table, index and packet
   assign pkt_rd_data = {1'b0, pkt_table, pkt_index} ^ pkt_num;
   always #5 pclk = ~pclk;
   sci_cmd_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .soft_reset(soft_reset), .rx_valid(rx_valid), .rx_data(rx_data),
      .rx_bcast(rx_bcast), .rx_ready(rx_ready), .tx_valid(tx_valid),
      .tx_data(tx_data), .tx_ready(tx_ready), .pkt_table(pkt_table),
      .pkt_num(pkt_num), .pkt_index(pkt_index), .pkt_rd_data(pkt_rd_data),
      .baud_232_fast(baud_232_fast), .baud_485_fast(baud_485_fast),
      .bcast_reply_en(bcast_reply_en));
   sci_host_model host (.pclk(pclk), .rx_ready(rx_ready),
      .tx_valid(tx_valid), .tx_data(tx_data), .rx_valid(rx_valid),
      .rx_data(rx_data), .tx_ready(tx_ready));
   task automatic print_verdict();
      $display("Comparisons %0d, mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // Hang guard
   initial begin
      repeat (30000) @(posedge pclk);
      err_total++;
      print_verdict();
   end
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      checks_done++;
      if (s !== e) begin
         err_total++;
         $display("Error at %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   // One APB transfer; answer taken at the edge where pready is high
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q, output logic e);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   function automatic logic [7:0] rb(input int i);
      return host.rep_q[7 + i];
   endfunction
   // One frame, its reply and framing checks
   task automatic cmd(input logic [23:0] op, input logic [7:0] len, d0, d1,
      input logic bad, input logic [7:0] code);
      logic [7:0] f[$];
      logic [7:0] s;
      int n;
      f = {8'h07, 8'hFF, op[23:16], op[15:8], op[7:0], len};
      s = 8'h00;
      foreach (f[i]) s += f[i];
      f.push_back(s);
      if (len > 8'h00) f.push_back(d0);
      if (len > 8'h01) f.push_back(d1);
      if (len > 8'h00) f.push_back(d0 + (len > 8'h01 ? d1 : 8'h00) + bad);
      host.rep_q.delete();
      host.send_frame(f);
      n = 0;
      while ((host.rep_q.size() < 6 || host.rep_q.size() < 8 + host.rep_q[5])
         && n < (code == 8'h00 ? 60 : 300)) begin
         @(negedge pclk);
         n++;
      end
      if (code == 8'h00) begin
         chk(host.rep_q.size(), 0);
      end else begin
         chk({host.rep_q[0], host.rep_q[1]}, {code, 8'hFF});
         chk({host.rep_q[2], host.rep_q[3], host.rep_q[4]}, op);
         s = 8'h00;
         for (int i = 0; i < 6; i++) s += host.rep_q[i];
         chk(host.rep_q[6], s);
         s = 8'h00;
         for (int i = 0; i < host.rep_q[5]; i++) s += rb(i);
         chk(rb(host.rep_q[5]), s);
      end
      repeat (3) @(posedge pclk);
   endtask
   task automatic t_regs();
      apb(1'b0, 8'h04, 32'h0, rd, er);
      chk(rd, 32'h0000_0004);
      apb(1'b0, 8'h1C, 32'h0, rd, er);
      chk({rd[30:0], er}, 32'h1);
      apb(1'b1, 8'h08, 32'h0041_4243, rd, er);
      apb(1'b1, 8'h18, 32'h0300_0005, rd, er);
      for (int i = 0; i < 3; i++)
         apb(1'b1, 8'h0C + 8'(4 * i), {8'h30 + 8'(i), 24'h0}, rd, er);
      $display("t_regs finished");
   endtask
   task automatic t_ver_fw();
      cmd(24'h564552, 8'h00, 8'h00, 8'h00, 1'b0, 8'h06);
      chk(host.rep_q[5], 8'h00);
      apb(1'b1, 8'h00, 32'h0000_0481, rd, er);
      cmd(24'h564552, 8'h00, 8'h00, 8'h00, 1'b0, 8'h06);
      chk({host.rep_q[5], rb(0), rb(1), rb(2)}, 32'h0341_4243);
      for (int i = 0; i < 3; i++) begin
         cmd(24'h465756, 8'h01, 8'(i), 8'h00, 1'b0, 8'h06);
         chk({host.rep_q[5], rb(0)}, {8'h04, 8'h30 + 8'(i)});
      end
      cmd(24'h465756, 8'h01, 8'h03, 8'h00, 1'b0, 8'h15);
      $display("t_ver_fw finished");
   endtask
   task automatic t_baud();
      host.slow <= 1'b1;
      cmd(24'h434252, 8'h02, 8'hFF, 8'hFF, 1'b0, 8'h06);
      chk({rb(0), rb(1), 6'h0, baud_485_fast, baud_232_fast}, 24'hFFFF02);
      cmd(24'h434252, 8'h01, 8'h00, 8'h00, 1'b0, 8'h06);
      chk({host.rep_q[5], rb(0), rb(1)}, 24'h020000);
      cmd(24'h434252, 8'h02, 8'h00, 8'h55, 1'b0, 8'h15);
      cmd(24'h434252, 8'h02, 8'h01, 8'hFF, 1'b0, 8'h15);
      soft_reset <= 1'b1;
      @(posedge pclk);
      soft_reset <= 1'b0;
      cmd(24'h434252, 8'h01, 8'hFF, 8'h00, 1'b0, 8'h06);
      chk({host.rep_q[5], rb(0), rb(1)}, 24'h02FFFF);
      host.slow <= 1'b0;
      $display("t_baud finished");
   endtask
   task automatic t_bcast();
      cmd(24'h42414B, 8'h01, 8'h00, 8'h00, 1'b0, 8'h06);
      chk({rb(0), 7'h0, bcast_reply_en}, 16'h0000);
      cmd(24'h42414B, 8'h00, 8'h00, 8'h00, 1'b0, 8'h06);
      chk({host.rep_q[5], rb(0)}, 16'h0100);
      rx_bcast <= 1'b1;
      cmd(24'h564552, 8'h00, 8'h00, 8'h00, 1'b0, 8'h00);
      rx_bcast <= 1'b0;
      cmd(24'h42414B, 8'h01, 8'hFF, 8'h00, 1'b0, 8'h06);
      chk({rb(0), 7'h0, bcast_reply_en}, 16'hFF01);
      $display("t_bcast finished");
   endtask
   task automatic t_dln();
      cmd(24'h444C4E, 8'h01, 8'h02, 8'h00, 1'b0, 8'h06);
      chk({host.rep_q[5], rb(0), rb(1)}, 24'h06022D);
      for (int i = 0; i < 4; i++) chk(rb(2 + i), 8'(i) ^ 8'h02);
      cmd(24'h444C4E, 8'h01, 8'h04, 8'h00, 1'b0, 8'h06);
      cmd(24'h444C4E, 8'h01, 8'h05, 8'h00, 1'b0, 8'h15);
      cmd(24'h444C4E, 8'h01, 8'h01, 8'h00, 1'b1, 8'h15);
      cmd(24'h444C4E, 8'h02, 8'h01, 8'h01, 1'b0, 8'h15);
      cmd(24'h444C4E, 8'h02, 8'h00, 8'h04, 1'b0, 8'h15);
      apb(1'b1, 8'h00, 32'h0000_0480, rd, er);
      cmd(24'h444C4E, 8'h01, 8'h00, 8'h00, 1'b0, 8'h15);
      apb(1'b1, 8'h00, 32'h0000_1E84, rd, er);
      cmd(24'h444C4E, 8'h01, 8'h01, 8'h00, 1'b0, 8'h06);
      chk({host.rep_q[5], rb(2), rb(31)}, 24'h20617C);
      cmd(24'h444C4E, 8'h02, 8'h02, 8'h00, 1'b0, 8'h06);
      chk({rb(0), rb(2)}, 16'h0202);
      $display("t_dln finished");
   endtask
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_regs();
      t_ver_fw();
      t_baud();
      t_bcast();
      t_dln();
      print_verdict();
   end
endmodule // serial_cmd_interface_download_test
`default_nettype wire
